// [hdl/rmc_defines.svh]
// Constants for the remote output mode control block
`ifndef RMC_DEFINES_SVH
`define RMC_DEFINES_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define RMC_CLK_MHZ 125
`define RMC_ONESHOT_MS 500
`define RMC_ONESHOT_CYCLES (`RMC_ONESHOT_MS * 1000 * `RMC_CLK_MHZ)
`define RMC_SHOT_W 26
`define RMC_SETTLE_CYCLES 3'h4

// ----------------------------------------------------------------
// Outputs, keys and identity store
// ----------------------------------------------------------------
`define RMC_NUM_OUT 6
`define RMC_KEY_W 3
`define RMC_ID_DEPTH 100
`define RMC_ID_AW 7
`define RMC_SYNC_W 3

// ----------------------------------------------------------------
// APB register map
// ----------------------------------------------------------------
`define RMC_ADDR_W 8
`define RMC_REG_STATUS 8'h00
`define RMC_REG_MASK 8'h04
`define RMC_REG_SLOT 8'h08
`define RMC_MASK_RST 6'h3f
`define RMC_SLOT_EN_BIT 8
`define RMC_ST_MODE_LSB 0
`define RMC_ST_PHASE_LSB 3
`define RMC_ST_OUT_LSB 5

`endif

// [hdl/rmc_pkg.sv]
// Types for the remote output mode control block
`include "rmc_defines.svh"

package rmc_pkg;

    // ------------------------------------------------------------
    // Modes and phases
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        RMC_ONESHOT,
        RMC_TOGGLE,
        RMC_SWITCH,
        RMC_CONT,
        RMC_IDLE
    } rmc_mode_t;

    typedef enum logic [1:0] {
        RMC_PH_SETTLE,
        RMC_PH_RUN,
        RMC_PH_CLEAR,
        RMC_PH_CLEARED
    } rmc_phase_t;

    // ------------------------------------------------------------
    // State records
    // ------------------------------------------------------------
    typedef struct packed {
        rmc_phase_t phase;
        rmc_mode_t mode;
        logic [2:0] settle;
        logic [`RMC_ID_AW-1:0] clr_addr;
        logic pend_vld;
        logic [`RMC_KEY_W-1:0] pend_key;
        logic pend_on;
        logic [`RMC_NUM_OUT-1:0] outs;
        logic [`RMC_NUM_OUT-1:0] contact;
        logic [`RMC_NUM_OUT-1:0] mask;
        logic [`RMC_NUM_OUT-1:0][`RMC_SHOT_W-1:0] shot;
        logic [31:0] prdata;
        logic pslverr;
        logic [`RMC_SLOT_EN_BIT:0] slot;
    } rmc_ctl_t;

    typedef struct packed {
        logic [`RMC_ID_DEPTH-1:0] valid;
        logic rdata;
    } rmc_mem_t;

    typedef struct packed {
        logic [`RMC_SYNC_W-1:0] meta;
        logic [`RMC_SYNC_W-1:0] sync;
    } rmc_sync_t;

endpackage : rmc_pkg

// [hdl/rmc_sync.sv]
// Two-stage synchroniser for the strap pins
`timescale 1ns/100ps
`default_nettype none
`include "rmc_defines.svh"

module rmc_sync (
    input wire logic clock,
    input wire logic rst,
    input wire logic [`RMC_SYNC_W-1:0] din,
    output logic [`RMC_SYNC_W-1:0] dout
);

    rmc_pkg::rmc_sync_t s;
    rmc_pkg::rmc_sync_t next_s;

    always_comb begin
        next_s = s;
        next_s.meta = din;
        next_s.sync = s.meta;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign dout = s.sync;

endmodule : rmc_sync
`default_nettype wire

// [hdl/rmc_id_mem.sv]
// Registered transmitter identity store, one valid flag per slot
`timescale 1ns/100ps
`default_nettype none
`include "rmc_defines.svh"

module rmc_id_mem (
    input wire logic clock,
    input wire logic rst,
    input wire logic we,
    input wire logic [`RMC_ID_AW-1:0] waddr,
    input wire logic wdata,
    input wire logic [`RMC_ID_AW-1:0] raddr,
    output logic rdata
);

    rmc_pkg::rmc_mem_t s;
    rmc_pkg::rmc_mem_t next_s;

    always_comb begin
        next_s = s;
        if (we && (waddr < `RMC_ID_AW'(`RMC_ID_DEPTH))) begin
            next_s.valid[waddr] = wdata;
        end
        if (raddr < `RMC_ID_AW'(`RMC_ID_DEPTH)) begin
            next_s.rdata = s.valid[raddr];
        end else begin
            next_s.rdata = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rdata = s.rdata;

endmodule : rmc_id_mem
`default_nettype wire

// [hdl/rmc_control.sv]
// Strap mode selection, contact output control and APB registers
`timescale 1ns/100ps
`default_nettype none
`include "rmc_defines.svh"

// Function
// - Straps A open, B and maintenance grounded at power-up select clear-all.
// - Clear-all erases every identity, then drives strap A low continuously.
// - Maintenance open: straps A and B choose one of four output modes.
// - Mode is latched only at power-up; later strap changes are ignored.
// - One-shot mode: key n on drives output n for 500 ms.
// - Toggle mode: each key n on command flips output n.
// - Switching mode: key 1 sets, key 2 clears output 4.
// - Switching mode: keys 3/4 drive output 5, keys 5/6 output 6.
// - Continuous mode: output n follows key n on until its off command.
// - On command acts at once, same latency in every mode.
// - Off command ends the output at once only in continuous mode; other modes ignore it.
// - All straps open at power-up resume normal reception.
module rmc_control #(
    parameter int ONESHOT_CYCLES = `RMC_ONESHOT_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic strap_a_in,
    output logic strap_a_out,
    output logic strap_a_oe,
    input wire logic strap_b_in,
    input wire logic maint_strap_in,
    input wire logic cmd_valid,
    input wire logic [`RMC_KEY_W-1:0] cmd_key,
    input wire logic cmd_on,
    input wire logic [`RMC_ID_AW-1:0] cmd_slot,
    output logic [`RMC_NUM_OUT-1:0] contact_out,
    output logic clear_done,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`RMC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic key_ok(input logic [`RMC_KEY_W-1:0] key);
        key_ok = (key >= `RMC_KEY_W'(1))
            && (key <= `RMC_KEY_W'(`RMC_NUM_OUT));
    endfunction : key_ok

    function automatic logic [`RMC_NUM_OUT-1:0] key_bit(
        input logic [`RMC_KEY_W-1:0] key
    );
        logic [`RMC_KEY_W-1:0] idx;

        idx = key - `RMC_KEY_W'(1);
        key_bit = `RMC_NUM_OUT'(1) << idx;
    endfunction : key_bit

    function automatic logic [`RMC_NUM_OUT-1:0] pair_bit(
        input logic [`RMC_KEY_W-1:0] key
    );
        logic [`RMC_KEY_W-1:0] idx;

        idx = 3'h3 + ((key - `RMC_KEY_W'(1)) >> 1);
        pair_bit = `RMC_NUM_OUT'(1) << idx;
    endfunction : pair_bit

    function automatic logic reg_hit(
        input logic [`RMC_ADDR_W-1:0] addr
    );
        unique case (addr)
            `RMC_REG_STATUS: reg_hit = 1'b1;
            `RMC_REG_MASK: reg_hit = 1'b1;
            `RMC_REG_SLOT: reg_hit = 1'b1;
            default: reg_hit = 1'b0;
        endcase
    endfunction : reg_hit

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam logic [`RMC_SHOT_W-1:0] SHOT_LOAD = `RMC_SHOT_W'(ONESHOT_CYCLES);

    rmc_pkg::rmc_ctl_t s;
    rmc_pkg::rmc_ctl_t next_s;

    logic [`RMC_SYNC_W-1:0] straps;
    logic mem_we;
    logic [`RMC_ID_AW-1:0] mem_waddr;
    logic mem_wdata;
    logic mem_rdata;
    logic setup;
    logic access;
    logic [31:0] status;
    logic cmd_take;
    logic cmd_apply;
    logic [`RMC_NUM_OUT-1:0] pend_bit;

    // ------------------------------------------------------------
    // Strap synchroniser and identity store
    // ------------------------------------------------------------
    rmc_sync u_sync (
        .clock(clock),
        .rst(rst),
        .din({maint_strap_in, strap_b_in, strap_a_in}),
        .dout(straps)
    );

    rmc_id_mem u_mem (
        .clock(clock),
        .rst(rst),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(cmd_slot),
        .rdata(mem_rdata)
    );

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    assign cmd_take = cmd_valid && (s.phase == rmc_pkg::RMC_PH_RUN)
        && key_ok(cmd_key);
    assign cmd_apply = s.pend_vld && mem_rdata;
    assign pend_bit = key_bit(s.pend_key);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign setup = psel && !penable;
    assign access = psel && penable;

    always_comb begin
        status = '0;

        status[`RMC_ST_MODE_LSB +: 3] = s.mode;
        status[`RMC_ST_PHASE_LSB +: 2] = s.phase;
        status[`RMC_ST_OUT_LSB +: `RMC_NUM_OUT] = s.contact;
    end

    // Identity writes: walker first, then software slot writes
    always_comb begin
        mem_we = 1'b0;
        mem_waddr = s.clr_addr;
        mem_wdata = 1'b0;

        if (s.phase == rmc_pkg::RMC_PH_CLEAR) begin
            mem_we = 1'b1;
        end else if (access && pwrite && (paddr == `RMC_REG_SLOT)) begin
            mem_we = 1'b1;
            mem_waddr = pwdata[`RMC_ID_AW-1:0];
            mem_wdata = pwdata[`RMC_SLOT_EN_BIT];
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;

        // Power-up strap capture
        unique case (s.phase)
            rmc_pkg::RMC_PH_SETTLE: begin
                next_s.settle = s.settle + 3'h1;
                if (s.settle == `RMC_SETTLE_CYCLES) begin
                    if (straps[2]) begin
                        next_s.phase = rmc_pkg::RMC_PH_RUN;
                        unique case (straps[1:0])
                            2'h3: begin
                                next_s.mode = rmc_pkg::RMC_ONESHOT;
                            end
                            2'h2: begin
                                next_s.mode = rmc_pkg::RMC_TOGGLE;
                            end
                            2'h1: begin
                                next_s.mode = rmc_pkg::RMC_SWITCH;
                            end
                            2'h0: begin
                                next_s.mode = rmc_pkg::RMC_CONT;
                            end
                        endcase
                    end else if (straps[1:0] == 2'h1) begin
                        next_s.phase = rmc_pkg::RMC_PH_CLEAR;
                        next_s.mode = rmc_pkg::RMC_IDLE;
                    end else begin
                        next_s.phase = rmc_pkg::RMC_PH_RUN;
                        next_s.mode = rmc_pkg::RMC_IDLE;
                    end
                end
            end

            rmc_pkg::RMC_PH_CLEAR: begin
                next_s.clr_addr = s.clr_addr + `RMC_ID_AW'(1);
                if (s.clr_addr == `RMC_ID_AW'(`RMC_ID_DEPTH - 1)) begin
                    next_s.phase = rmc_pkg::RMC_PH_CLEARED;
                end
            end

            rmc_pkg::RMC_PH_RUN: begin
                next_s.phase = s.phase;
            end

            rmc_pkg::RMC_PH_CLEARED: begin
                next_s.phase = s.phase;
            end
        endcase

        // Command pipeline: slot lookup, then apply
        next_s.pend_vld = cmd_take;
        next_s.pend_key = cmd_key;
        next_s.pend_on = cmd_on;

        // One-shot timers
        for (int i = 0; i < `RMC_NUM_OUT; i++) begin
            if (s.shot[i] != '0) begin
                next_s.shot[i] = s.shot[i] - `RMC_SHOT_W'(1);
                if (s.shot[i] == `RMC_SHOT_W'(1)) begin
                    next_s.outs[i] = 1'b0;
                end
            end
        end

        if (cmd_apply) begin
            unique case (s.mode)
                rmc_pkg::RMC_ONESHOT: begin
                    if (s.pend_on) begin
                        next_s.outs = next_s.outs | key_bit(s.pend_key);
                        for (int i = 0; i < `RMC_NUM_OUT; i++) begin
                            if (pend_bit[i]) begin
                                next_s.shot[i] = SHOT_LOAD;
                            end
                        end
                    end
                end

                rmc_pkg::RMC_TOGGLE: begin
                    if (s.pend_on) begin
                        next_s.outs = s.outs ^ key_bit(s.pend_key);
                    end
                end

                rmc_pkg::RMC_SWITCH: begin
                    if (s.pend_on) begin
                        if (s.pend_key[0]) begin
                            next_s.outs = s.outs | pair_bit(s.pend_key);
                        end else begin
                            next_s.outs = s.outs & ~pair_bit(s.pend_key);
                        end
                    end
                end

                rmc_pkg::RMC_CONT: begin
                    if (s.pend_on) begin
                        next_s.outs = s.outs | key_bit(s.pend_key);
                    end else begin
                        next_s.outs = s.outs & ~key_bit(s.pend_key);
                    end
                end

                rmc_pkg::RMC_IDLE: begin
                    next_s.outs = s.outs;
                end

                default: begin
                    next_s.outs = '0;
                end
            endcase
        end

        // APB registers
        if (setup) begin
            next_s.pslverr = !reg_hit(paddr);
            next_s.prdata = '0;
            if (!pwrite) begin
                unique case (paddr)
                    `RMC_REG_STATUS: begin
                        next_s.prdata = status;
                    end
                    `RMC_REG_MASK: begin
                        next_s.prdata = 32'(s.mask);
                    end
                    `RMC_REG_SLOT: begin
                        next_s.prdata = 32'(s.slot);
                    end
                    default: begin
                        next_s.prdata = '0;
                    end
                endcase
            end
        end
        if (access && pwrite) begin
            unique case (paddr)
                `RMC_REG_MASK: begin
                    next_s.mask = pwdata[`RMC_NUM_OUT-1:0];
                end
                `RMC_REG_SLOT: begin
                    next_s.slot = pwdata[`RMC_SLOT_EN_BIT:0];
                end
                default: begin
                    next_s.slot = s.slot;
                end
            endcase
        end

        next_s.contact = next_s.outs & next_s.mask;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            s <= '0;
            s.phase <= rmc_pkg::RMC_PH_SETTLE;
            s.mode <= rmc_pkg::RMC_IDLE;
            s.mask <= `RMC_MASK_RST;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign contact_out = s.contact;
    assign clear_done = (s.phase == rmc_pkg::RMC_PH_CLEARED);

    assign strap_a_out = 1'b0;
    assign strap_a_oe = clear_done;

    assign prdata = s.prdata;
    assign pready = access;
    assign pslverr = access && s.pslverr;

endmodule : rmc_control
`default_nettype wire

// [verification/rmc_keypad.sv]
// Keypad transmitter model delivering decoded on/off commands
`timescale 1ns/100ps
`default_nettype none

module rmc_keypad #(
    parameter int FRAME_CYC = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic go,
    input wire logic [2:0] key,
    input wire logic on,
    input wire logic [6:0] slot,
    output logic busy,
    output logic cmd_valid,
    output logic [2:0] cmd_key,
    output logic cmd_on,
    output logic [6:0] cmd_slot
);
    // ------------------------------------------------------------
    // Frame delay, then one command; idle fields keep changing
    // ------------------------------------------------------------
    logic [7:0] cnt;
    logic [2:0] k;
    logic o;
    logic [6:0] s;

    always_ff @(posedge clock) begin
        cmd_valid <= 1'b0;
        cmd_key <= ~cmd_key;
        cmd_on <= ~cmd_on;
        cmd_slot <= ~cmd_slot;
        if (rst) begin
            busy <= 1'b0;
            cmd_key <= 3'h0;
            cmd_on <= 1'b0;
            cmd_slot <= 7'h00;
        end else if (go && !busy) begin
            busy <= 1'b1;
            cnt <= 8'(FRAME_CYC);
            k <= key;
            o <= on;
            s <= slot;
        end else if (busy && cnt == 8'h00) begin
            busy <= 1'b0;
            cmd_valid <= 1'b1;
            cmd_key <= k;
            cmd_on <= o;
            cmd_slot <= s;
        end else if (busy) begin
            cnt <= cnt - 8'h01;
        end
    end
endmodule : rmc_keypad
`default_nettype wire

// [verification/rmc_control_assertions.sv]
// Assertion checker for the remote output mode control block
`timescale 1ns/100ps
`default_nettype none
`include "rmc_defines.svh"

module rmc_control_chk #(
    parameter int ONESHOT_CYCLES = `RMC_ONESHOT_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic strap_a_in,
    input wire logic strap_a_out,
    input wire logic strap_a_oe,
    input wire logic strap_b_in,
    input wire logic maint_strap_in,
    input wire logic cmd_valid,
    input wire logic cmd_on,
    input wire logic [`RMC_NUM_OUT-1:0] contact_out,
    input wire logic clear_done,
    input wire logic psel,
    input wire logic penable,
    input wire logic [`RMC_ADDR_W-1:0] paddr,
    input wire logic pready,
    input wire logic pslverr
);
    // ------------------------------------------------------------
    // Cycles since reset
    // ------------------------------------------------------------
    logic [7:0] age;
    logic acc;
    assign acc = psel && penable;
    always_ff @(posedge clock) begin
        if (rst) begin
            age <= 8'h00;
        end else if (age != 8'hff) begin
            age <= age + 8'h01;
        end
    end

    AST_RESET_OUTS: assert property (@(posedge clock)
        rst |=> contact_out == '0 && !strap_a_oe) else $error("outputs not cleared");
    AST_CLEAR_TIME: assert property (@(posedge clock) disable iff (rst)
        $fell(rst) && !maint_strap_in && strap_a_in && !strap_b_in |-> ##[100:200] strap_a_oe)
        else $error("clear-all never finished");
    AST_OE_EARLY: assert property (@(posedge clock) disable iff (rst)
        strap_a_oe |-> age >= 8'h64) else $error("strap A driven before erase");
    AST_OE_PIN: assert property (@(posedge clock) disable iff (rst)
        strap_a_oe |-> !strap_a_out && clear_done) else $error("strap A not driven low");
    AST_OE_HOLDS: assert property (@(posedge clock) disable iff (rst)
        $rose(strap_a_oe) |=> strap_a_oe [*8]) else $error("strap A drive released");
    AST_RISE_CAUSE: assert property (@(posedge clock) disable iff (rst)
        (contact_out & ~$past(contact_out)) != '0 |-> $past(cmd_valid, 2) && $past(cmd_on, 2))
        else $error("output rose without on command");
    AST_PREADY: assert property (@(posedge clock) disable iff (rst)
        pready == acc) else $error("pready not in access cycle");
    AST_ERR: assert property (@(posedge clock) disable iff (rst)
        acc |-> pslverr == !(paddr inside {`RMC_REG_STATUS, `RMC_REG_MASK, `RMC_REG_SLOT}))
        else $error("pslverr wrong");

    cover property (@(posedge clock) $rose(strap_a_oe));
    cover property (@(posedge clock) (contact_out & ~$past(contact_out)) != '0);
    cover property (@(posedge clock) acc && pslverr);
endmodule : rmc_control_chk

bind rmc_control rmc_control_chk #(.ONESHOT_CYCLES(ONESHOT_CYCLES)) rmc_control_chk_inst (
    .clock(clock), .rst(rst), .strap_a_in(strap_a_in), .strap_a_out(strap_a_out),
    .strap_a_oe(strap_a_oe), .strap_b_in(strap_b_in), .maint_strap_in(maint_strap_in),
    .cmd_valid(cmd_valid), .cmd_on(cmd_on), .contact_out(contact_out),
    .clear_done(clear_done), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr)
);
`default_nettype wire

// [verification/remote_output_mode_control_tb.sv]
// Self-checking testbench for the remote output mode control block
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end

module remote_output_mode_control_tb;
    localparam int ONE = 20;
    logic clock, rst, sa, strap_a_in, strap_a_out, strap_a_oe, strap_b_in, maint_strap_in;
    logic go, on, cmd_valid, cmd_on, clear_done, busy, psel, penable, pwrite, pready;
    logic pslverr, er;
    logic [2:0] key, cmd_key;
    logic [6:0] slot, cmd_slot;
    logic [5:0] contact_out;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int n_errors = 0;
    int check_count = 0;

    assign strap_a_in = strap_a_oe ? strap_a_out : sa;

    rmc_control #(.ONESHOT_CYCLES(ONE)) rmc_control_inst (
        .clock(clock), .rst(rst), .strap_a_in(strap_a_in), .strap_a_out(strap_a_out),
        .strap_a_oe(strap_a_oe), .strap_b_in(strap_b_in), .maint_strap_in(maint_strap_in),
        .cmd_valid(cmd_valid), .cmd_key(cmd_key), .cmd_on(cmd_on), .cmd_slot(cmd_slot),
        .contact_out(contact_out), .clear_done(clear_done), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr)
    );
    rmc_keypad #(.FRAME_CYC(8)) rmc_keypad_inst (
        .clock(clock), .rst(rst), .go(go), .key(key), .on(on), .slot(slot), .busy(busy),
        .cmd_valid(cmd_valid), .cmd_key(cmd_key), .cmd_on(cmd_on), .cmd_slot(cmd_slot)
    );

    // ------------------------------------------------------------
    // Expected outputs and bus tasks
    // ------------------------------------------------------------
    function automatic logic [5:0] nxt(input int m, input logic [5:0] c, input int k,
                                       input logic o);
        logic [5:0] r;
        r = c;
        if (m == 1 && o) r[k-1] = ~c[k-1];
        if (m == 2 && o) r[3+(k-1)/2] = k[0];
        if (m == 3) r[k-1] = o;
        return r;
    endfunction : nxt

    task automatic step(input int n);
        repeat (n) @(posedge clock);
    endtask : step

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        step(1);
        penable <= 1'b1;
        do begin
            step(1);
            t++;
        end while (pready !== 1'b1 && t < 20);
        if (pready !== 1'b1) n_errors++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        step(1);
    endtask : apb

    task automatic power(input logic m, input logic a, input logic b);
        rst <= 1'b1;
        maint_strap_in <= m;
        sa <= a;
        strap_b_in <= b;
        step(12);
        rst <= 1'b0;
        step(10);
    endtask : power

    task automatic press(input int k, input logic o, input logic [6:0] s);
        int t;
        t = 0;
        go <= 1'b1;
        key <= k[2:0];
        on <= o;
        slot <= s;
        step(1);
        go <= 1'b0;
        do begin
            step(1);
            t++;
        end while (busy === 1'b1 && t < 40);
        if (busy === 1'b1) n_errors++;
        step(3);
    endtask : press

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    // ------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    initial begin
        repeat (40000) @(posedge clock);
        n_errors++;
        close_out();
    end

    initial begin
        int k;
        logic o;
        logic [5:0] e;
        rst = 1'b1;
        go = 1'b0;
        key = 3'h0;
        on = 1'b0;
        slot = 7'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sa = 1'b1;
        strap_b_in = 1'b1;
        maint_strap_in = 1'b1;
        void'($urandom(87310));
        for (int m = 0; m < 4; m++) begin
            power(1'b1, ~m[0], ~m[1]);
            `CHK(contact_out, 6'h00)
            apb(1'b0, 8'h00, 32'h0);
            `CHK(rd[2:0], m[2:0])
            `CHK(rd[4:3], 2'h1)
            apb(1'b1, 8'h08, 32'h105);
            press(1, 1'b1, 7'h09);
            `CHK(contact_out, 6'h00)
            press(7, 1'b1, 7'h05);
            `CHK(contact_out, 6'h00)
            e = 6'h00;
            for (int i = 0; i < 14; i++) begin
                k = (i < 6) ? i + 1 : int'($urandom_range(6, 1));
                o = (i < 6) ? 1'b1 : 1'($urandom_range(1, 0));
                press(k, o, 7'h05);
                if (m == 0) begin
                    e[k-1] = o;
                    `CHK(contact_out, e)
                    step(ONE - 6);
                    `CHK(contact_out, e)
                    step(8);
                    e = 6'h00;
                    `CHK(contact_out, e)
                end else begin
                    e = nxt(m, e, k, o);
                    `CHK(contact_out, e)
                end
            end
            sa <= ~sa;
            strap_b_in <= ~strap_b_in;
            step(6);
            apb(1'b0, 8'h00, 32'h0);
            `CHK(rd[2:0], m[2:0])
            `CHK(rd[10:5], e)
            $display("mode %0d test done", m);
        end
        power(1'b0, 1'b1, 1'b0);
        k = 0;
        while (strap_a_oe !== 1'b1 && k < 300) begin
            step(1);
            k++;
        end
        `CHK(strap_a_in, 1'b0)
        `CHK(clear_done, 1'b1)
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rd[4:3], 2'h3)
        apb(1'b0, 8'h10, 32'h0);
        `CHK(er, 1'b1)
        `CHK(rd, 32'h0)
        $display("clear and bus error test done");
        power(1'b0, 1'b1, 1'b1);
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rd[2:0], 3'h4)
        `CHK(rd[4:3], 2'h1)
        $display("idle mode test done");
        close_out();
    end
endmodule : remote_output_mode_control_tb
`default_nettype wire
